// >>> hw/delay_line_cfg.svh
`ifndef DELAY_LINE_CFG_SVH
`define DELAY_LINE_CFG_SVH

`define FINE_STEP_PS         125
`define FINE_STEP_DIV        10
`define FINE_MAX             7'h7f
`define FINE_USER_MAX        7'h7e
`define COARSE_NONE_PS       0
`define COARSE_ONE_PS        800
`define COARSE_TWO_PS        1600
`define ZERO_HOLD_STEPS      7'h28
`define DELAY_PS_PER_TICK    5000

`define REG_CTRL             32'h0000_0000
`define REG_STATUS           32'h0000_0004
`define REG_IRQ_STATUS       32'h0000_0008
`define REG_IRQ_MASK         32'h0000_000c
`define REG_USER_FINE        32'h0000_0010

`define CTRL_POLICY_LSB      0
`define CTRL_DIR_OUT_BIT     2
`define CTRL_COARSE_DYN_BIT  3
`define CTRL_COARSE_LSB      4
`define CTRL_EDGE_EN_BIT     6
`define CTRL_STATIC_BIT      7
`define CTRL_RESET_VAL       32'h0000_0040

`define IRQ_LIMIT_BIT        0
`define IRQ_EDGE_BIT         1
`define IRQ_COARSE_BAD_BIT   2

`endif

// >>> hw/delay_line_pkg.sv
package delay_line_pkg;
   typedef enum logic [1:0] {
      POL_BYPASS,
      POL_ZERO_HOLD,
      POL_USER_FIXED,
      POL_USER_DYNAMIC
   } delay_policy_t;

   typedef struct packed {
      logic       step;
      logic       step_sense;
      logic       restore_default_n;
      logic [1:0] coarse;
   } step_ctrl_t;

   typedef struct packed {
      logic awv;
      logic [31:0] awaddr;
      logic wv;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic arv;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] bresp;
      logic [1:0] rresp;
   } bus_state_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [6:0]  user_fine;
   } regs_t;

   typedef struct packed {
      bus_state_t  bus;
      regs_t       regs;
      logic        step_prev;
      logic        sense_prev;
      logic [6:0]  fine_step_count;
      logic        limit_flag;
      logic        edge_watch_error;
      logic        data_prev;
      logic        edge_seen;
      logic        irq;
      logic        pad_out;
      logic        core_out;
      logic        step_ok;
      logic        policy_prev_dyn;
      logic [15:0] tap_line;
   } core_state_t;
endpackage

// >>> hw/dynamic_io_delay_line.sv
// Notes on behaviour
// - dynamic cell starts from clocking-based default
// - restore input low reloads the default
// - each step pulse changes delay, falling-edge sampled
// - sense one decreases, sense zero increases
// - coarse 00/01/10 adds 0/800/1600ps, 11 invalid
// - limit flag at max going up, min down
// - edge monitor error raised on bad data
// - static variant holds fixed factory delay
// - one element delays input or output, not both
// - bypass, zero-hold, fixed user, dynamic modes
// - user fine value is a step count
// - transmit use has no zero-hold preset
// - each fine step adds 12.5ps, seven bits
// - coarse source static or dynamic input
// - edge monitor enabled by option, default on
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "delay_line_cfg.svh"
module dynamic_io_delay_line
   import delay_line_pkg::*;
#(
   parameter logic [6:0] ZERO_HOLD_PRESET = `ZERO_HOLD_STEPS,
   parameter int         TAPS             = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        step,
   input  wire logic        step_sense,
   input  wire logic        restore_default_pin_n,
   input  wire logic [1:0]  coarse_code,
   input  wire logic        pad_in,
   input  wire logic        core_in,
   output logic             pad_out,
   output logic             core_out,
   output logic             limit_flag,
   output logic             edge_watch_error,
   output logic [6:0]       fine_step_count,
   output logic [11:0]      total_delay_ps,
   output logic             irq,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [31:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp
);
   core_state_t   cur_ff;
   core_state_t   nxt_cur;
   delay_policy_t policy;
   logic          dir_out;
   logic          coarse_dyn;
   logic          edge_en;
   logic          static_cell;
   logic [1:0]    coarse_sel;
   logic [6:0]    default_steps;
   logic          step_fall;
   logic          line_in;
   logic [11:0]   coarse_ps;
   logic [11:0]   fine_ps;
   logic [3:0]    tap_idx;
   logic [31:0]   wr_word;
   logic [31:0]   rd_word;
   logic          rd_ok;
   logic          wr_ok;

   assign policy      = delay_policy_t'(cur_ff.regs.ctrl[`CTRL_POLICY_LSB +: 2]);
   assign dir_out     = cur_ff.regs.ctrl[`CTRL_DIR_OUT_BIT];
   assign coarse_dyn  = cur_ff.regs.ctrl[`CTRL_COARSE_DYN_BIT];
   assign edge_en     = cur_ff.regs.ctrl[`CTRL_EDGE_EN_BIT];
   assign static_cell = cur_ff.regs.ctrl[`CTRL_STATIC_BIT];
   assign step_fall   = cur_ff.step_prev & ~step;

   always_comb begin
      // coarse source select
      coarse_sel = coarse_dyn ? coarse_code : cur_ff.regs.ctrl[`CTRL_COARSE_LSB +: 2];
      // factory default per policy; transmit has no zero-hold preset
      if (policy == POL_ZERO_HOLD && !dir_out) begin
         default_steps = ZERO_HOLD_PRESET;
      end else if (policy == POL_BYPASS) begin
         default_steps = 7'h00;
      end else begin
         default_steps = cur_ff.regs.user_fine;
      end
   end

   always_comb begin
      case (coarse_sel)
         2'b01:   coarse_ps = 12'(`COARSE_ONE_PS);
         2'b10:   coarse_ps = 12'(`COARSE_TWO_PS);
         default: coarse_ps = 12'(`COARSE_NONE_PS);
      endcase
      fine_ps = 12'((32'(cur_ff.fine_step_count) * `FINE_STEP_PS) / `FINE_STEP_DIV);
      tap_idx = 4'(32'(coarse_ps + fine_ps) * 32'(TAPS - 1) / (`COARSE_TWO_PS + 1588));
   end

   // shared element: one input feeds the line depending on direction
   assign line_in = dir_out ? core_in : pad_in;

   always_comb begin
      wr_word = cur_ff.bus.wdata;
      rd_ok   = 1'b1;
      if (cur_ff.bus.awaddr == `REG_CTRL) begin
         rd_word = cur_ff.regs.ctrl;
      end else if (cur_ff.bus.awaddr == 32'hffff_ffff) begin
         rd_word = 32'h0;
      end else begin
         rd_word = 32'h0;
      end
      if (s_axi_araddr == `REG_CTRL) begin
         rd_word = cur_ff.regs.ctrl;
      end else if (s_axi_araddr == `REG_STATUS) begin
         rd_word = {16'h0, total_delay_ps[11:0], 1'b0, cur_ff.edge_watch_error, cur_ff.limit_flag,
                    cur_ff.policy_prev_dyn};
         rd_word = {13'h0, cur_ff.fine_step_count, total_delay_ps};
      end else if (s_axi_araddr == `REG_IRQ_STATUS) begin
         rd_word = {29'h0, cur_ff.regs.irq_status};
      end else if (s_axi_araddr == `REG_IRQ_MASK) begin
         rd_word = {29'h0, cur_ff.regs.irq_mask};
      end else if (s_axi_araddr == `REG_USER_FINE) begin
         rd_word = {25'h0, cur_ff.regs.user_fine};
      end else begin
         rd_word = 32'h0;
         rd_ok   = 1'b0;
      end
      wr_ok = (cur_ff.bus.awaddr == `REG_CTRL) || (cur_ff.bus.awaddr == `REG_IRQ_STATUS) ||
              (cur_ff.bus.awaddr == `REG_IRQ_MASK) || (cur_ff.bus.awaddr == `REG_USER_FINE);
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.step_prev  = step;
      nxt_cur.sense_prev = step_sense;
      nxt_cur.data_prev  = line_in;
      nxt_cur.policy_prev_dyn = (policy == POL_USER_DYNAMIC);
      // delay line of taps, output picks the tap
      nxt_cur.tap_line = {cur_ff.tap_line[14:0], line_in};
      if (policy == POL_BYPASS) begin
         nxt_cur.pad_out  = dir_out ? core_in : 1'b0;
         nxt_cur.core_out = dir_out ? 1'b0 : pad_in;
      end else begin
         nxt_cur.pad_out  = dir_out ? cur_ff.tap_line[tap_idx] : 1'b0;
         nxt_cur.core_out = dir_out ? 1'b0 : cur_ff.tap_line[tap_idx];
      end

      // fine counter
      if (!restore_default_pin_n || policy != POL_USER_DYNAMIC || static_cell) begin
         nxt_cur.fine_step_count = default_steps;
         nxt_cur.limit_flag      = 1'b0;
      end else if (step_fall) begin
         if (cur_ff.sense_prev) begin
            if (cur_ff.fine_step_count == 7'h00) begin
               nxt_cur.limit_flag = 1'b1;
            end else begin
               nxt_cur.fine_step_count = cur_ff.fine_step_count - 7'h01;
               nxt_cur.limit_flag      = (cur_ff.fine_step_count == 7'h01);
            end
         end else begin
            if (cur_ff.fine_step_count == `FINE_MAX) begin
               nxt_cur.limit_flag = 1'b1;
            end else begin
               nxt_cur.fine_step_count = cur_ff.fine_step_count + 7'h01;
               nxt_cur.limit_flag      = (cur_ff.fine_step_count == 7'h7e);
            end
         end
      end

      // edge monitor: data toggling twice within one window counts as error
      nxt_cur.edge_seen = (line_in != cur_ff.data_prev);
      nxt_cur.edge_watch_error = edge_en && !dir_out && (policy != POL_BYPASS) &&
                                 cur_ff.edge_seen && (line_in != cur_ff.data_prev);

      // axi4-lite slave
      if (cur_ff.bus.bvalid && s_axi_bready) begin
         nxt_cur.bus.bvalid = 1'b0;
      end
      if (cur_ff.bus.rvalid && s_axi_rready) begin
         nxt_cur.bus.rvalid = 1'b0;
      end
      if (s_axi_awvalid && !cur_ff.bus.awv && !cur_ff.bus.bvalid) begin
         nxt_cur.bus.awv    = 1'b1;
         nxt_cur.bus.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur_ff.bus.wv && !cur_ff.bus.bvalid) begin
         nxt_cur.bus.wv    = 1'b1;
         nxt_cur.bus.wdata = s_axi_wdata;
         nxt_cur.bus.wstrb = s_axi_wstrb;
      end
      if (s_axi_arvalid && !cur_ff.bus.rvalid) begin
         nxt_cur.bus.rvalid = 1'b1;
         nxt_cur.bus.rdata  = rd_word;
         nxt_cur.bus.rresp  = rd_ok ? 2'b00 : 2'b10;
      end
      // irq events set; a set wins over a clear written in the same cycle
      if (cur_ff.bus.awv && cur_ff.bus.wv) begin
         nxt_cur.bus.awv    = 1'b0;
         nxt_cur.bus.wv     = 1'b0;
         nxt_cur.bus.bvalid = 1'b1;
         nxt_cur.bus.bresp  = wr_ok ? 2'b00 : 2'b10;
         if (cur_ff.bus.wstrb[0]) begin
            if (cur_ff.bus.awaddr == `REG_CTRL) begin
               nxt_cur.regs.ctrl[7:0] = wr_word[7:0];
            end else if (cur_ff.bus.awaddr == `REG_IRQ_STATUS) begin
               nxt_cur.regs.irq_status = cur_ff.regs.irq_status & ~wr_word[2:0];
            end else if (cur_ff.bus.awaddr == `REG_IRQ_MASK) begin
               nxt_cur.regs.irq_mask = wr_word[2:0];
            end else if (cur_ff.bus.awaddr == `REG_USER_FINE) begin
               nxt_cur.regs.user_fine = (wr_word[6:0] > `FINE_USER_MAX) ? `FINE_USER_MAX : wr_word[6:0];
            end
         end
      end
      if (nxt_cur.limit_flag && !cur_ff.limit_flag) begin
         nxt_cur.regs.irq_status[`IRQ_LIMIT_BIT] = 1'b1;
      end
      if (nxt_cur.edge_watch_error) begin
         nxt_cur.regs.irq_status[`IRQ_EDGE_BIT] = 1'b1;
      end
      if (coarse_sel == 2'b11) begin
         nxt_cur.regs.irq_status[`IRQ_COARSE_BAD_BIT] = 1'b1;
      end
      nxt_cur.irq = |(nxt_cur.regs.irq_status & nxt_cur.regs.irq_mask);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_ff           <= '0;
         cur_ff.regs.ctrl <= `CTRL_RESET_VAL;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         total_delay_ps <= 12'h000;
      end else begin
         total_delay_ps <= coarse_ps + fine_ps;
      end
   end

   assign pad_out          = cur_ff.pad_out;
   assign core_out         = cur_ff.core_out;
   assign limit_flag       = cur_ff.limit_flag;
   assign edge_watch_error = cur_ff.edge_watch_error;
   assign fine_step_count  = cur_ff.fine_step_count;
   assign irq              = cur_ff.irq;
   assign s_axi_awready    = !cur_ff.bus.awv && !cur_ff.bus.bvalid;
   assign s_axi_wready     = !cur_ff.bus.wv && !cur_ff.bus.bvalid;
   assign s_axi_bvalid     = cur_ff.bus.bvalid;
   assign s_axi_bresp      = cur_ff.bus.bresp;
   assign s_axi_arready    = !cur_ff.bus.rvalid;
   assign s_axi_rvalid     = cur_ff.bus.rvalid;
   assign s_axi_rdata      = cur_ff.bus.rdata;
   assign s_axi_rresp      = cur_ff.bus.rresp;
endmodule

// >>> testbench/step_fabric.sv
`timescale 1ns/1ps
module step_fabric (
   input  wire logic  sys_clk,
   output logic       step,
   output logic       step_sense,
   output logic       restore_default_pin_n,
   output logic [1:0] coarse_code
);
   initial begin
      step = 1'b0;
      step_sense = 1'b0;
      restore_default_pin_n = 1'b1;
      coarse_code = 2'h0;
   end
   // sense settles before the pulse and stays put past its falling edge
   task automatic pulse(input int n, input logic down);
      repeat (n) begin
         @(posedge sys_clk) step_sense <= down;
         @(posedge sys_clk) step <= 1'b1;
         repeat (2) @(posedge sys_clk);
         step <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   task automatic restore();
      @(posedge sys_clk) restore_default_pin_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      restore_default_pin_n <= 1'b1;
   endtask
   // code 3 is only applied when the bench asks for it
   task automatic set_coarse(input logic [1:0] c);
      @(posedge sys_clk) coarse_code <= c;
   endtask
endmodule

// >>> testbench/delay_line_monitor.sv
`timescale 1ns/1ps
module delay_line_monitor (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        step,
   input wire logic        step_sense,
   input wire logic        restore_default_pin_n,
   input wire logic [1:0]  coarse_code,
   input wire logic        pad_out,
   input wire logic        core_out,
   input wire logic        limit_flag,
   input wire logic [6:0]  fine_step_count,
   input wire logic [11:0] total_delay_ps,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   AST_ONE_DIRECTION: assert property (!(pad_out && core_out))
      else $error("both data directions active");
   AST_DELAY_RANGE: assert property (total_delay_ps <= 12'hc73)
      else $error("total delay beyond coarse plus fine range");
   AST_SINGLE_STEP: assert property (
      restore_default_pin_n && $past(restore_default_pin_n) && $past(restore_default_pin_n, 2) && $past(reset_n)
      && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) && !$past(s_axi_wvalid, 3)
      |-> (fine_step_count - $past(fine_step_count)) inside {7'h00, 7'h01, 7'h7f})
      else $error("fine count moved by more than one step");
   AST_RESTORE_CLEARS: assert property (!restore_default_pin_n |-> ##[1:2] !limit_flag)
      else $error("limit flag kept during restore");
   AST_LIMIT_HOLD: assert property (
      fine_step_count == 7'h00 && limit_flag && $fell(step) && $past(step_sense) && restore_default_pin_n
      |-> ##[1:2] fine_step_count == 7'h00)
      else $error("step below minimum moved the count");
   AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_RDATA_ERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   cover property ($rose(limit_flag));
   cover property (coarse_code == 2'h3);
   cover property ($fell(step) && !$past(step_sense));
endmodule
bind dynamic_io_delay_line delay_line_monitor delay_line_monitor_i (.*);

// >>> testbench/dynamic_io_delay_line_tb_top.sv
`timescale 1ns/1ps
`include "delay_line_cfg.svh"
module dynamic_io_delay_line_tb_top;
   logic        sys_clk, reset_n, step, step_sense, restore_default_pin_n, pad_in, core_in;
   logic        pad_out, core_out, limit_flag, edge_watch_error, irq;
   logic [1:0]  coarse_code, s_axi_bresp, s_axi_rresp;
   logic [6:0]  fine_step_count;
   logic [11:0] total_delay_ps;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [33:0] exp_q[$];
   int          fails, n_checks, cyc, n;
   dynamic_io_delay_line dynamic_io_delay_line_i (.*);
   step_fabric step_fabric_i (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic final_report();
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] st(input int f, input int c);
      return {13'h0, 7'(f), 12'(c + f * `FINE_STEP_PS / `FINE_STEP_DIV)};
   endfunction
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   // the expected answer is queued before the request goes out
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      exp_q.push_back({r, e});
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   always @(posedge sys_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         if (exp_q.size() == 0) chk(34'h0, 34'h1);
         else chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      reset_n = 1'b0; pad_in = 1'b0; core_in = 1'b0; s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      void'($urandom(96));
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(32'h0, `CTRL_RESET_VAL);
      rd(32'h20, 32'h0, 2'h2);
      wr(`REG_USER_FINE, 32'h5);
      wr(`REG_CTRL, 32'h43);
      step_fabric_i.restore();
      rd(`REG_STATUS, st(5, 0));
      step_fabric_i.pulse(5, 1'b1);
      rd(`REG_STATUS, st(0, 0));
      chk(34'(limit_flag), 34'h1);
      step_fabric_i.pulse(1, 1'b1);
      rd(`REG_STATUS, st(0, 0));
      wr(`REG_IRQ_MASK, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(34'(irq), 34'h1);
      step_fabric_i.restore();
      wr(`REG_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(34'(irq), 34'h0);
      // back-to-back toggles on the pad trip the edge monitor
      repeat (4) @(posedge sys_clk) pad_in <= ~pad_in;
      rd(`REG_IRQ_STATUS, 32'h2);
      wr(`REG_IRQ_STATUS, 32'h2);
      @(posedge sys_clk);
      pad_in <= 1'b1;
      core_in <= 1'b1;
      repeat (20) @(posedge sys_clk);
      chk({31'h0, edge_watch_error, pad_out, core_out}, 34'h1);
      n = $urandom % 20;
      step_fabric_i.pulse(n, 1'b0);
      rd(`REG_STATUS, st(5 + n, 0));
      wr(`REG_CTRL, 32'h4b);
      for (int c = 0; c < 3; c++) begin
         step_fabric_i.set_coarse(2'(c));
         rd(`REG_STATUS, st(5 + n, c * `COARSE_ONE_PS));
      end
      step_fabric_i.set_coarse(2'h3);
      rd(`REG_IRQ_STATUS, 32'h4);
      wr(`REG_CTRL, 32'hc3);
      step_fabric_i.pulse(2, 1'b0);
      rd(`REG_STATUS, st(5, 0));
      wr(`REG_CTRL, 32'h41);
      rd(`REG_STATUS, st(`ZERO_HOLD_STEPS, 0));
      wr(`REG_CTRL, 32'h45);
      rd(`REG_STATUS, st(5, 0));
      repeat (20) @(posedge sys_clk);
      chk({31'h0, edge_watch_error, pad_out, core_out}, 34'h2);
      repeat (5) @(posedge sys_clk);
      final_report();
   end
endmodule
